/* File: adc_ctl_cfg.svh */
/*
 * Constants of the serial converter control block: frame lengths, address
 * field positions, reset levels of the pin synchronisers and power timing.
 * Assumes a 50 MHz system clock; times are given in ns and turned into cycles.
 */
`ifndef ADC_CTL_CFG_SVH
`define ADC_CTL_CFG_SVH

// ****************************************************************
// frame layout, counted in serial clock edges
// ****************************************************************
`define ADDR_CLKS       4'h5
`define ACQ_CLKS        4'h4
`define CONV_CLKS       4'hC
`define RES_BITS        4'hB
`define RES_MSB         10
`define SAR_FIRST_TRIAL 11'h400

// ****************************************************************
// address field positions inside the shifted five-bit address
// ****************************************************************
`define ADR_PU          4
`define ADR_SGL         3
`define ADR_ODD         2
`define ADR_SEL_HI      1
`define ADR_SEL_LO      0
`define ADR_RESET       5'h00

// ****************************************************************
// pin synchroniser reset levels: pd, serial_in, sclk, cs_n
// ****************************************************************
`define PIN_COUNT       4
`define PIN_INIT        4'h1

// ****************************************************************
// power timing
// ****************************************************************
`define CLK_PERIOD_NS   20
`define PD_TIME_NS      1000
`define PC_TIME_NS      10000
`define PD_CYC          (`PD_TIME_NS / `CLK_PERIOD_NS)
`define PC_CYC          ((`PC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWR_CNT_MAX     10'h3FF

`endif

/* File: adc_ctl_pkg.sv */
/*
 * Types shared by the converter control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package adc_ctl_pkg;
    // gray codes along idle, address, acquire, convert, output, done
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_ACQ  = 3'h3,
        ST_CONV = 3'h2,
        ST_OUT  = 3'h6,
        ST_DONE = 3'h7
    } state_e;
endpackage

`default_nettype wire

/* File: pin_sync.sv */
/*
 * Three-stage synchroniser for one asynchronous pin with agreement filter.
 * Assumes the pin is asynchronous to clk_sys; the output is a clean level.
 */
`default_nettype none

module pin_sync #(
    parameter bit INIT = 1'b0
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // pin and filtered level
    input  wire logic pin,
    output var  logic level
);
    logic [2:0] ff_q;
    logic [2:0] ff_d;
    logic       level_q;
    logic       level_d;

    // ****************************************************************
    // shift chain; the first stage feeds only the second
    // ****************************************************************
    always_comb begin
        ff_d    = {ff_q[1:0], pin};
        level_d = level_q;
        if (ff_q[1] == ff_q[2]) begin
            level_d = ff_q[2];  // change taken once stages two and three agree
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ff_q    <= {3{INIT}};
            level_q <= INIT;
        end else begin
            ff_q    <= ff_d;
            level_q <= level_d;
        end
    end

    assign level = level_q;
endmodule

`default_nettype wire

/* File: adc_ctl.sv */
/*
 * Digital control of a serial successive-approximation converter with input
 * multiplexer: frame sequencing, address capture, SAR stepping, result
 * shifting and power control. All pins arrive asynchronously and are
 * oversampled by clk_sys; the comparator input is synchronous to clk_sys.
 */
// What this block does
// - address fields: powerup, single-ended, odd/sign, pair select
// - power-down reaches low power within one microsecond
// - select high releases data and busy outputs
// - data output changes after falling serial clock, except each word's first bit
// - select high holds result until next select
// - select low mode shifts result right after conversion
// - serial input sampled on rising serial clock
// - powerdown pin forces power-down regardless of address
// - select low mode gives highest throughput
`default_nettype none
`include "adc_ctl_cfg.svh"

module adc_ctl (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // host pins
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        serial_in,
    input  wire logic        powerdown_pin,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic             conversion_busy_flag,
    output logic             conversion_busy_flag_oe,
    // analog core
    input  wire logic        comparator_high,
    output logic [10:0]      dac_trial,
    output logic             mux_connect,
    output logic             single_ended_select,
    output logic [2:0]       pos_channel,
    output logic [2:0]       neg_channel,
    output logic             bias_enable,
    output logic             converter_ready
);
    localparam int PD_BOUND = `PD_CYC + 1;
    // one reset level per pin, picked bit by bit so each synchroniser gets one bit
    localparam logic [`PIN_COUNT-1:0] PIN_INIT_V = `PIN_INIT;

    logic [`PIN_COUNT-1:0] pins;
    logic [`PIN_COUNT-1:0] pins_s;
    logic                  cs_hi, sclk_s, sin_s, pdp_s;
    logic                  sclk_prev_q, rise, fall;

    adc_ctl_pkg::state_e   state_q, state_d;
    logic [3:0]            cnt_q, cnt_d;
    logic [4:0]            addr_sh_q, addr_sh_d, addr_q, addr_d, new_addr;
    logic [10:0]           sar_q, sar_d, mask_q, mask_d, result_q, result_d;
    logic [10:0]           out_sh_q, out_sh_d;
    logic                  so_q, so_d, so_oe_q, so_oe_d, busy_q, busy_d, busy_oe_q, busy_oe_d;

    logic                  req, req_q, bias_q, bias_d, ready_q, ready_d;
    logic [9:0]            pwr_cnt_q, pwr_cnt_d;
    logic                  mux_q, mux_d, sgl_q, sgl_d;
    logic [2:0]            pos_q, pos_d, neg_q, neg_d;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    assign pins = {powerdown_pin, serial_in, sclk, cs_n};

    for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_sync
        pin_sync #(
            .INIT (PIN_INIT_V[i])
        ) u_sync (
            .clk_sys (clk_sys),
            .rstn    (rstn),
            .pin     (pins[i]),
            .level   (pins_s[i])
        );
    end

    assign cs_hi  = pins_s[0];
    assign sclk_s = pins_s[1];
    assign sin_s  = pins_s[2];
    assign pdp_s  = pins_s[3];
    assign rise   = sclk_s & ~sclk_prev_q;
    assign fall   = ~sclk_s & sclk_prev_q;
    assign new_addr = {addr_sh_q[3:0], sin_s};

    // ****************************************************************
    // frame sequencer, next values
    // ****************************************************************
    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        addr_sh_d = addr_sh_q;
        addr_d    = addr_q;
        sar_d     = sar_q;
        mask_d    = mask_q;
        result_d  = result_q;
        out_sh_d  = out_sh_q;
        so_d      = so_q;
        so_oe_d   = so_oe_q;
        busy_d    = busy_q;
        busy_oe_d = busy_oe_q;
        if (cs_hi && state_q != adc_ctl_pkg::ST_CONV) begin
            // select high resets the frame; a finished result stays put
            state_d   = adc_ctl_pkg::ST_IDLE;
            so_oe_d   = 1'b0;
            busy_oe_d = 1'b0;
            busy_d    = 1'b0;
        end else begin
            unique case (state_q)
                adc_ctl_pkg::ST_IDLE: begin
                    // frame start: present the stored result first bit
                    state_d   = adc_ctl_pkg::ST_ADDR;
                    cnt_d     = 4'h0;
                    out_sh_d  = result_q;
                    so_d      = result_q[`RES_MSB];
                    so_oe_d   = 1'b1;
                    busy_oe_d = 1'b1;
                end
                adc_ctl_pkg::ST_ADDR: begin
                    if (rise) begin
                        addr_sh_d = new_addr;
                        cnt_d     = cnt_q + 4'h1;
                        if (cnt_q == `ADDR_CLKS - 4'h1) begin
                            addr_d  = new_addr;
                            cnt_d   = 4'h0;
                            state_d = new_addr[`ADR_PU] ? adc_ctl_pkg::ST_ACQ
                                                        : adc_ctl_pkg::ST_DONE;
                        end
                    end
                end
                adc_ctl_pkg::ST_ACQ: begin
                    if (rise) begin
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == `ACQ_CLKS - 4'h1) begin
                            state_d = adc_ctl_pkg::ST_CONV;
                            cnt_d   = 4'h0;
                            sar_d   = `SAR_FIRST_TRIAL;
                            mask_d  = `SAR_FIRST_TRIAL;
                            busy_d  = 1'b1;
                        end
                    end
                end
                adc_ctl_pkg::ST_CONV: begin
                    // conversion runs on even with select high
                    so_oe_d   = ~cs_hi;
                    busy_oe_d = ~cs_hi;
                    if (rise) begin
                        cnt_d  = cnt_q + 4'h1;
                        sar_d  = (comparator_high ? sar_q : (sar_q & ~mask_q)) | (mask_q >> 1);
                        mask_d = mask_q >> 1;
                        if (cnt_q == `CONV_CLKS - 4'h1) begin
                            result_d = sar_q;
                            busy_d   = 1'b0;
                            cnt_d    = 4'h0;
                            if (cs_hi) begin
                                state_d = adc_ctl_pkg::ST_IDLE;
                            end else begin
                                state_d  = adc_ctl_pkg::ST_OUT;
                                out_sh_d = sar_q;
                                so_d     = sar_q[`RES_MSB];
                            end
                        end
                    end
                end
                adc_ctl_pkg::ST_OUT: begin
                    if (fall) begin
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == `RES_BITS - 4'h2) begin
                            state_d = adc_ctl_pkg::ST_DONE;
                        end
                    end
                end
                adc_ctl_pkg::ST_DONE: begin
                    state_d = adc_ctl_pkg::ST_DONE;   // waits for select high
                end
                default: begin
                    state_d = adc_ctl_pkg::ST_IDLE;
                end
            endcase
            // after a word's first bit, data moves only after a falling serial clock edge; shifting on through
            // conversion lets all eleven bits of the held word leave before the new one
            if (fall && state_q inside {adc_ctl_pkg::ST_ADDR, adc_ctl_pkg::ST_ACQ,
                                        adc_ctl_pkg::ST_CONV, adc_ctl_pkg::ST_OUT}) begin
                out_sh_d = {out_sh_q[9:0], 1'b0};
                so_d     = out_sh_q[`RES_MSB-1];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q     <= adc_ctl_pkg::ST_IDLE;
            cnt_q       <= 4'h0;
            addr_sh_q   <= `ADR_RESET;
            addr_q      <= `ADR_RESET;
            sar_q       <= 11'h000;
            mask_q      <= 11'h000;
            result_q    <= 11'h000;
            out_sh_q    <= 11'h000;
            so_q        <= 1'b0;
            so_oe_q     <= 1'b0;
            busy_q      <= 1'b0;
            busy_oe_q   <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            addr_sh_q   <= addr_sh_d;
            addr_q      <= addr_d;
            sar_q       <= sar_d;
            mask_q      <= mask_d;
            result_q    <= result_d;
            out_sh_q    <= out_sh_d;
            so_q        <= so_d;
            so_oe_q     <= so_oe_d;
            busy_q      <= busy_d;
            busy_oe_q   <= busy_oe_d;
            sclk_prev_q <= sclk_s;
        end
    end

    // ****************************************************************
    // power control and multiplexer decode, next values
    // ****************************************************************
    // the pin wins over the address so a board can force sleep
    assign req = addr_q[`ADR_PU] & ~pdp_s;

    always_comb begin
        pwr_cnt_d = (req != req_q) ? 10'h000
                  : (pwr_cnt_q == `PWR_CNT_MAX) ? pwr_cnt_q : pwr_cnt_q + 10'h001;
        bias_d    = bias_q;
        ready_d   = 1'b0;
        if (req) begin
            bias_d  = 1'b1;
            ready_d = (req == req_q) && (pwr_cnt_q >= 10'(`PC_CYC - 1));
        end else if (req == req_q && pwr_cnt_q >= 10'(`PD_CYC - 1)) begin
            bias_d  = 1'b0;
        end
        // inputs disconnect at once; only the bias ramps down
        mux_d = req;
        sgl_d = addr_q[`ADR_SGL];
        pos_d = {addr_q[`ADR_SEL_HI], addr_q[`ADR_SEL_LO], addr_q[`ADR_ODD]};
        neg_d = {addr_q[`ADR_SEL_HI], addr_q[`ADR_SEL_LO], ~addr_q[`ADR_ODD]};
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            req_q     <= 1'b0;
            pwr_cnt_q <= 10'h000;
            bias_q    <= 1'b0;
            ready_q   <= 1'b0;
            mux_q     <= 1'b0;
            sgl_q     <= 1'b0;
            pos_q     <= 3'h0;
            neg_q     <= 3'h0;
        end else begin
            req_q     <= req;
            pwr_cnt_q <= pwr_cnt_d;
            bias_q    <= bias_d;
            ready_q   <= ready_d;
            mux_q     <= mux_d;
            sgl_q     <= sgl_d;
            pos_q     <= pos_d;
            neg_q     <= neg_d;
        end
    end

    // outputs straight from flip-flops
    assign serial_out              = so_q;
    assign serial_out_oe           = so_oe_q;
    assign conversion_busy_flag    = busy_q;
    assign conversion_busy_flag_oe = busy_oe_q;
    assign dac_trial               = sar_q;
    assign mux_connect             = mux_q;
    assign single_ended_select     = sgl_q;
    assign pos_channel             = pos_q;
    assign neg_channel             = neg_q;
    assign bias_enable             = bias_q;
    assign converter_ready         = ready_q;

    // ****************************************************************
    // assertions and covers
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_tristate_on_cs: assert property (cs_hi |=> !so_oe_q && !busy_oe_q)
        else $error("outputs driven while select high");
    a_out_on_fall: assert property (
        state_q == adc_ctl_pkg::ST_OUT && !fall && !cs_hi |=> $stable(so_q))
        else $error("data output moved without falling clock");
    a_addr_rise_sample: assert property (
        state_q == adc_ctl_pkg::ST_ADDR && rise && !cs_hi |=> addr_sh_q[0] == $past(sin_s))
        else $error("serial input not sampled on rising edge");
    a_pd_pin_force: assert property (pdp_s |=> !mux_q)
        else $error("powerdown pin did not disconnect inputs");
    a_pd_settle_time: assert property (
        $fell(req_q) ##1 !req_q [*2] |-> ##[0:PD_BOUND] !bias_q)
        else $error("bias not removed in power-down time");
    a_direct_output: assert property (
        state_q == adc_ctl_pkg::ST_CONV && rise && cnt_q == `CONV_CLKS - 4'h1 && !cs_hi
        |=> state_q == adc_ctl_pkg::ST_OUT && so_q == result_q[`RES_MSB])
        else $error("result not shifted right after conversion");
    a_hold_result: assert property (
        state_q == adc_ctl_pkg::ST_IDLE && cs_hi |=> $stable(result_q))
        else $error("held result changed while deselected");
    a_mux_fields: assert property (
        ##1 mux_q |-> pos_q[0] == $past(addr_q[`ADR_ODD]) && sgl_q == $past(addr_q[`ADR_SGL]))
        else $error("multiplexer decode mismatch");

    c_direct_mode: cover property (state_q == adc_ctl_pkg::ST_CONV
                                   && state_d == adc_ctl_pkg::ST_OUT);
    c_delayed_mode: cover property (state_q == adc_ctl_pkg::ST_CONV
                                    && state_d == adc_ctl_pkg::ST_IDLE);
    c_pin_powerdown: cover property (addr_q[`ADR_PU] && pdp_s && !bias_q);
    c_ready: cover property ($rose(ready_q));
endmodule

`default_nettype wire

/* File: adc_host_model.sv */
/*
 * Host controller model: drives chip select, serial clock and address bits,
 * samples the result and busy lines just before each serial clock fall.
 * Assumes the bench resolves released lines and shares clk_sys.
 */
`default_nettype none

module adc_host_model (
    // clock
    input  wire logic clk_sys,
    // host pins
    output var  logic cs_n,
    output var  logic sclk,
    output var  logic serial_in,
    input  wire logic data_line,
    input  wire logic busy_line
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // serial clock half period, in clk_sys cycles
    // ****************************************************************
    // well above the four cycles the pin filter needs
    localparam int HALF = 8;

    // idle pins: deselected, clock standing low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
    end

    // all pin changes land on the falling clk_sys edge
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // one serial period: data set while low, sampled before the fall
    task automatic pulse(input logic din, output logic dout, output logic bout);
        serial_in = din;
        wait_clk(HALF);
        sclk = 1'b1;
        wait_clk(HALF - 1);
        dout = data_line;
        bout = busy_line;
        wait_clk(1);
        sclk = 1'b0;
    endtask

    // select, then address powerup bit first while reading back
    task automatic frame(input logic [4:0] addr, input int rises,
                         output logic [31:0] dat, output logic [31:0] bsy);
        dat = '0;
        bsy = '0;
        cs_n = 1'b0;
        wait_clk(HALF);
        for (int k = 0; k < rises; k++)
            pulse((k < 5) ? addr[4 - k] : 1'b0, dat[k], bsy[k]);
    endtask

    // deselect; clock keeps running so a pending conversion can finish
    task automatic deselect(input int periods);
        logic d;
        logic b;
        cs_n = 1'b1;
        for (int k = 0; k < periods; k++)
            pulse(1'b0, d, b);
    endtask
endmodule

`default_nettype wire

/* File: serial_adc_mux_control_bench.sv */
/*
 * Self-checking bench of the converter control block with a host model.
 * Assumes the design header's timing constants and a 50 MHz clk_sys.
 */
`default_nettype none
`include "adc_ctl_cfg.svh"

module serial_adc_mux_control_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************************************
    // signals
    // ****************************************************************
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        powerdown_pin = 1'b0;
    wire logic   cs_n, sclk, serial_in, serial_out, serial_out_oe;
    wire logic   conversion_busy_flag, conversion_busy_flag_oe;
    wire logic   mux_connect, single_ended_select, bias_enable, converter_ready;
    wire logic [10:0] dac_trial;
    logic [10:0] target = 11'h000;
    wire logic [2:0]  pos_channel, neg_channel;
    logic        data_last = 1'b0;
    logic        busy_last = 1'b0;
    logic [15:0] up_cnt = 16'h0000;
    logic [31:0] dat, bsy;
    int          error_cnt = 0;
    int          comparisons = 0;
    wire logic   comparator_high;
    wire logic   data_line;
    wire logic   busy_line;

    always #10 clk_sys = ~clk_sys;

    // analog stand-in: trial kept while it does not exceed the target
    assign comparator_high = (dac_trial <= target);
    // released lines show the inverse of their last driven level
    assign data_line = serial_out_oe ? serial_out : ~data_last;
    assign busy_line = conversion_busy_flag_oe ? conversion_busy_flag : ~busy_last;

    // last driven levels and power-up settle counter
    always @(posedge clk_sys) begin
        if (serial_out_oe) data_last <= serial_out;
        if (conversion_busy_flag_oe) busy_last <= conversion_busy_flag;
        if (!mux_connect) up_cnt <= 16'h0000;
        else if (!converter_ready) up_cnt <= up_cnt + 16'h0001;
    end

    adc_ctl uut (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .sclk(sclk),
        .serial_in(serial_in), .powerdown_pin(powerdown_pin), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .conversion_busy_flag(conversion_busy_flag),
        .conversion_busy_flag_oe(conversion_busy_flag_oe),
        .comparator_high(comparator_high), .dac_trial(dac_trial),
        .mux_connect(mux_connect), .single_ended_select(single_ended_select),
        .pos_channel(pos_channel), .neg_channel(neg_channel),
        .bias_enable(bias_enable), .converter_ready(converter_ready));

    adc_host_model host (.clk_sys(clk_sys), .cs_n(cs_n), .sclk(sclk),
        .serial_in(serial_in), .data_line(data_line), .busy_line(busy_line));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // eleven samples from index s, first sample is the msb
    function automatic logic [10:0] word(input logic [31:0] v, input int s);
        logic [10:0] w;
        for (int i = 0; i < 11; i++)
            w[10 - i] = v[s + i];
        return w;
    endfunction

    // bounded wait for the settle flag, then judge its delay
    task automatic wait_ready();
        int n;
        n = 0;
        while (converter_ready !== 1'b1 && n < 2000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 2000) begin
            error_cnt++;
            $display("FAIL at %0t ns: ready never came", $time);
            close_out();
        end else begin
            check((up_cnt >= `PC_CYC - 4) && (up_cnt <= `PC_CYC + 4),
                  1'b1, "settle time");
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // first frame powers up; its result is not used
    task automatic t_powerup_first();
        check(serial_out_oe, 1'b0, "data released before any frame");
        host.frame(5'b11000, 31, dat, bsy);
        host.deselect(6);
        check({mux_connect, single_ended_select, pos_channel, neg_channel},
              8'h81 | 8'h40, "pair zero single-ended");
        wait_ready();
        $display("test powerup_first done");
    endtask

    // select held low: result follows conversion in the same frame
    task automatic t_fast_mode();
        logic [4:0]  tbl [4];
        logic [10:0] prev;
        tbl = '{5'b11101, 5'b10110, 5'b10011, 5'b11010};
        prev = 11'h000;
        for (int i = 0; i < 4; i++) begin
            target = {tbl[i], 6'h2B};
            host.frame(tbl[i], 31, dat, bsy);
            if (i > 0) check(word(dat, 0), prev, "previous result first");
            check(word(dat, 20), target, "result in same frame");
            check(bsy[20:7], 14'h1FFE, "busy window");
            check({single_ended_select, pos_channel, neg_channel}, {tbl[i][3], tbl[i][1],
                  tbl[i][0], tbl[i][2], tbl[i][1], tbl[i][0], ~tbl[i][2]}, "fields");
            prev = target;
            host.deselect(6);
        end
        $display("test fast_mode done");
    endtask

    // select raised mid-conversion: outputs let go, result kept
    task automatic t_delayed();
        target = 11'h64E;
        host.frame(5'b11000, 12, dat, bsy);
        host.deselect(0);
        host.wait_clk(8);
        check({serial_out_oe, conversion_busy_flag_oe}, 2'b00, "lines released");
        host.deselect(14);
        target = 11'h0F0;
        host.frame(5'b11000, 31, dat, bsy);
        check(word(dat, 0), 11'h64E, "held result shifted out");
        host.deselect(6);
        $display("test delayed done");
    endtask

    // pin and address power-down
    task automatic t_powerdown();
        powerdown_pin = 1'b1;
        host.wait_clk(10);
        check(mux_connect, 1'b0, "pin disconnects inputs");
        host.wait_clk(`PD_CYC);
        check(bias_enable, 1'b0, "bias off after pin");
        host.frame(5'b11000, 8, dat, bsy);
        host.deselect(6);
        check(mux_connect, 1'b0, "pin beats address");
        // wake by the pin, then hold off the next conversion until settled
        powerdown_pin = 1'b0;
        wait_ready();
        host.frame(5'b11000, 31, dat, bsy);
        host.deselect(6);
        host.frame(5'b01000, 8, dat, bsy);
        host.deselect(1);
        check(mux_connect, 1'b0, "powerup bit clear");
        host.wait_clk(`PD_CYC + 8);
        check(bias_enable, 1'b0, "bias off after address");
        $display("test powerdown done");
    endtask

    // main sequence
    initial begin
        repeat (3) @(negedge clk_sys);
        rstn = 1'b1;
        host.wait_clk(8);
        t_powerup_first();
        t_fast_mode();
        t_delayed();
        t_powerdown();
        close_out();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        error_cnt++;
        $display("FAIL at %0t ns: run limit reached", $time);
        close_out();
    end
endmodule

`default_nettype wire
